// ### verilog/mcp_pkg.sv
/*
 * constants for the module control pin logic: register offsets, field
 * positions and reset values. assumes a plain strobe register port.
 */
// Operation
// (R1) transmitter off when pin high or soft bit
// (R2) tx-off pin level mirrored to status bit
// (R3) pin14 select bit: analog input or open drain
// (R4) pin14 output drives active-low interrupt request
// (R5) rx-rate output is pin OR soft bit
// (R6) rx-rate pin level mirrored to status bit
// (R7) aux pin: general output or pulsed reset
// (R8) shared pin shows signal loss below threshold
// (R9) signal-loss polarity follows config bit 3
// (R10) loss deasserts when power exceeds threshold
// (R11) signal-absent flag reads actual pin level; code inverts it while config bit 3 set
// (R12) config bit 2 set selects tx-rate output
// (R13) config bit 4 clear: rx-rate, open drain
// (R14) config bit 4 set: general output, configurable drive
// (R15) tx-rate pin level mirrored to status bit
// (R16) open-drain outputs pull low or release
package mcp_pkg;
    // register offsets
    localparam logic [3:0] ADDR_USER_CTL  = 4'h0;
    localparam logic [3:0] ADDR_OEM_CFG3  = 4'h1;
    localparam logic [3:0] ADDR_OEM_CFG6  = 4'h2;
    localparam logic [3:0] ADDR_STATUS    = 4'h3;
    localparam logic [3:0] ADDR_SOFT_CTL  = 4'h4;
    localparam logic [3:0] ADDR_RESET_CTL = 4'h5;
    localparam logic [3:0] ADDR_THRESH    = 4'h6;

    // user control fields
    localparam int USR_PIN14_OUT_SEL = 4;

    // oem config byte 3 fields
    localparam int CFG3_GPO_LEVEL    = 0;
    localparam int CFG3_GPO_PUSHPULL = 1;
    localparam int CFG3_AUX_GPO_LVL  = 3;
    localparam int CFG3_PIN20_GPO    = 4;
    localparam int CFG3_AUX_IS_RESET = 7;

    // oem config byte 6 fields
    localparam int CFG6_TX_RATE_SEL  = 2;
    localparam int CFG6_LOS_POLARITY = 3;

    // soft control fields
    localparam int SOFT_TX_OFF       = 0;
    localparam int SOFT_RX_RATE      = 1;
    localparam int SOFT_TX_RATE      = 2;

    // status fields
    localparam int STS_TX_OFF_PIN    = 0;
    localparam int STS_RX_RATE_PIN   = 1;
    localparam int STS_TX_RATE_PIN   = 2;
    localparam int STS_SIG_ABSENT    = 3;
    localparam int STS_RESET_ACTIVE  = 4;

    // reset control: bits 0..2 hold the pulse request
    localparam logic [2:0] RESET_REQ_NONE = 3'h0;

    // reset values
    localparam logic [7:0] USER_CTL_RST = 8'h00;
    localparam logic [7:0] OEM_CFG3_RST = 8'h00;
    localparam logic [7:0] OEM_CFG6_RST = 8'h00;
    localparam logic [7:0] SOFT_CTL_RST = 8'h00;
    localparam logic [7:0] THRESH_RST   = 8'h00;
endpackage : mcp_pkg

// ### verilog/mcp_module_control_pin_logic.sv
/*
 * digital pin-function logic: combines hard pins with soft bits, mirrors
 * pin levels to status, and muxes the shared open-drain pins.
 * assumes synchronous pin inputs, a digitised rx power sample and an
 * interrupt request from elsewhere; pin levels resolved outside.
 */
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module mcp_module_control_pin_logic #(
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          arst_n,
    // register port
    input  wire logic [3:0]    regAddr,
    input  wire logic [DW-1:0] regWrData,
    input  wire logic          regWrStb,
    input  wire logic          regRdStb,
    output logic      [DW-1:0] regRdData,
    // host pins in
    input  wire logic          txOffPin,
    input  wire logic          rxRateSelectPin,
    input  wire logic          txRateSelectPin,
    // front-end
    input  wire logic [DW-1:0] rxPowerInput,
    input  wire logic          irqReq,
    output logic               tx_off_pin,
    output logic               supplySenseEnable,
    // supply-sense or interrupt pin
    output logic               irqPinOut,
    output logic               irqPinOe,
    // aux open-drain pin
    output logic               auxOdPinOut,
    output logic               auxOdPinOe,
    // signal-absent or tx-rate pin
    input  wire logic          sigAbsentPinIn,
    output logic               sigAbsentPinOut,
    output logic               sigAbsentPinOe,
    // rx-rate or general output pin
    output logic               rxRatePinOut,
    output logic               rxRatePinOe,
    // reset pulse request to the timing logic
    output logic [2:0]         resetPulseReq
);

    logic [DW-1:0] userCtl_ff, nxt_userCtl;
    logic [DW-1:0] oem_config_byte_3_ff, nxt_oem_config_byte_3;
    logic [DW-1:0] oem_config_byte_6_ff, nxt_oem_config_byte_6;
    logic [DW-1:0] softCtl_ff, nxt_softCtl;
    logic [DW-1:0] thresh_ff,  nxt_thresh;
    logic [2:0]    resetReq_ff, nxt_resetReq;
    logic [DW-1:0] status_ff,  nxt_status;
    logic [DW-1:0] rdData_ff,  nxt_rdData;
    logic          sigLoss_ff, nxt_sigLoss;
    logic          txRateOut;
    logic          rxRateOut;
    logic          lossDrive;

    // combined functions
    assign tx_off_pin = txOffPin | softCtl_ff[mcp_pkg::SOFT_TX_OFF];           // [R1]
    assign rxRateOut = rxRateSelectPin | softCtl_ff[mcp_pkg::SOFT_RX_RATE];   // [R5]
    assign txRateOut = txRateSelectPin | softCtl_ff[mcp_pkg::SOFT_TX_RATE];   // [R12]
    assign resetPulseReq = resetReq_ff;

    // register writes, loss comparator, status mirror, read data
    always_comb begin
        nxt_userCtl  = userCtl_ff;
        nxt_oem_config_byte_3  = oem_config_byte_3_ff;
        nxt_oem_config_byte_6  = oem_config_byte_6_ff;
        nxt_softCtl  = softCtl_ff;
        nxt_thresh   = thresh_ff;
        nxt_resetReq = resetReq_ff;
        nxt_rdData   = '0;
        if (regWrStb) begin
            case (regAddr)
                mcp_pkg::ADDR_USER_CTL:  nxt_userCtl  = regWrData;
                mcp_pkg::ADDR_OEM_CFG3:  nxt_oem_config_byte_3  = regWrData;
                mcp_pkg::ADDR_OEM_CFG6:  nxt_oem_config_byte_6  = regWrData;
                mcp_pkg::ADDR_SOFT_CTL:  nxt_softCtl  = regWrData;
                mcp_pkg::ADDR_RESET_CTL: nxt_resetReq = regWrData[2:0];
                mcp_pkg::ADDR_THRESH:    nxt_thresh   = regWrData;
                default: ;
            endcase
        end
        // loss while power at or below threshold, clears above it
        nxt_sigLoss = !(rxPowerInput > thresh_ff);                            // [R8] [R10]
        nxt_status = '0;
        nxt_status[mcp_pkg::STS_TX_OFF_PIN]   = txOffPin;                     // [R2]
        nxt_status[mcp_pkg::STS_RX_RATE_PIN]  = rxRateSelectPin;              // [R6]
        nxt_status[mcp_pkg::STS_TX_RATE_PIN]  = txRateSelectPin;              // [R15]
        // pin level xor loss polarity bit, so normal state shown as configured
        nxt_status[mcp_pkg::STS_SIG_ABSENT]   =
            sigAbsentPinIn ^ oem_config_byte_6_ff[mcp_pkg::CFG6_LOS_POLARITY];          // [R11]
        nxt_status[mcp_pkg::STS_RESET_ACTIVE] = (resetReq_ff != mcp_pkg::RESET_REQ_NONE);
        if (regRdStb) begin
            case (regAddr)
                mcp_pkg::ADDR_USER_CTL:  nxt_rdData = userCtl_ff;
                mcp_pkg::ADDR_OEM_CFG3:  nxt_rdData = oem_config_byte_3_ff;
                mcp_pkg::ADDR_OEM_CFG6:  nxt_rdData = oem_config_byte_6_ff;
                mcp_pkg::ADDR_STATUS:    nxt_rdData = status_ff;
                mcp_pkg::ADDR_SOFT_CTL:  nxt_rdData = softCtl_ff;
                mcp_pkg::ADDR_RESET_CTL: nxt_rdData = {{(DW-3){1'b0}}, resetReq_ff};
                mcp_pkg::ADDR_THRESH:    nxt_rdData = thresh_ff;
                default:                 nxt_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            userCtl_ff  <= mcp_pkg::USER_CTL_RST;
            oem_config_byte_3_ff  <= mcp_pkg::OEM_CFG3_RST;
            oem_config_byte_6_ff  <= mcp_pkg::OEM_CFG6_RST;
            softCtl_ff  <= mcp_pkg::SOFT_CTL_RST;
            thresh_ff   <= mcp_pkg::THRESH_RST;
            resetReq_ff <= mcp_pkg::RESET_REQ_NONE;
            status_ff   <= '0;
            rdData_ff   <= '0;
            sigLoss_ff  <= 1'b0;
        end else begin
            userCtl_ff  <= nxt_userCtl;
            oem_config_byte_3_ff  <= nxt_oem_config_byte_3;
            oem_config_byte_6_ff  <= nxt_oem_config_byte_6;
            softCtl_ff  <= nxt_softCtl;
            thresh_ff   <= nxt_thresh;
            resetReq_ff <= nxt_resetReq;
            status_ff   <= nxt_status;
            rdData_ff   <= nxt_rdData;
            sigLoss_ff  <= nxt_sigLoss;
        end
    end

    assign regRdData = rdData_ff;

    // pin muxing; open drain only ever drives low
    always_comb begin
        // pin 14: analog sense or active-low interrupt
        supplySenseEnable = !userCtl_ff[mcp_pkg::USR_PIN14_OUT_SEL];         // [R3]
        irqPinOut = 1'b0;                                                     // [R16]
        irqPinOe  = userCtl_ff[mcp_pkg::USR_PIN14_OUT_SEL] & irqReq;          // [R3] [R4]
        // aux pin: reset pulse pulls low, else general level
        auxOdPinOut = 1'b0;                                                   // [R16]
        if (oem_config_byte_3_ff[mcp_pkg::CFG3_AUX_IS_RESET])
            auxOdPinOe = (resetReq_ff != mcp_pkg::RESET_REQ_NONE);            // [R7]
        else
            auxOdPinOe = !oem_config_byte_3_ff[mcp_pkg::CFG3_AUX_GPO_LVL];              // [R7]
        // shared loss / tx-rate pin, polarity on loss only
        if (oem_config_byte_6_ff[mcp_pkg::CFG6_TX_RATE_SEL])
            lossDrive = txRateOut;                                            // [R12]
        else
            lossDrive = sigLoss_ff ^ oem_config_byte_6_ff[mcp_pkg::CFG6_LOS_POLARITY];  // [R8] [R9]
        sigAbsentPinOut = 1'b0;                                               // [R16]
        sigAbsentPinOe  = !lossDrive;
        // pin 20: rx-rate open drain, or general output
        if (oem_config_byte_3_ff[mcp_pkg::CFG3_PIN20_GPO]) begin
            if (oem_config_byte_3_ff[mcp_pkg::CFG3_GPO_PUSHPULL]) begin
                rxRatePinOut = oem_config_byte_3_ff[mcp_pkg::CFG3_GPO_LEVEL];           // [R14]
                rxRatePinOe  = 1'b1;
            end else begin
                rxRatePinOut = 1'b0;
                rxRatePinOe  = !oem_config_byte_3_ff[mcp_pkg::CFG3_GPO_LEVEL];          // [R14] [R16]
            end
        end else begin
            rxRatePinOut = 1'b0;                                              // [R13] [R16]
            rxRatePinOe  = !rxRateOut;                                        // [R13]
        end
    end

endmodule : mcp_module_control_pin_logic

// ### testbench/mcp_front_model.sv
/* host board and front-end model: pull-ups on the open-drain pins.
   assumes the design drives low only through its enables. */
`timescale 1ns/1ps
module mcp_front_model (
    // pin drives
    input  wire logic sigAbsentPinOe,
    input  wire logic rxRatePinOut,
    input  wire logic rxRatePinOe,
    input  wire logic extPull,
    // resolved levels
    output logic      sigAbsentPinIn,
    output logic      rxLvl
);
    // released lines float high, external circuit may wire-or low
    assign sigAbsentPinIn = !(sigAbsentPinOe || extPull);
    assign rxLvl = rxRatePinOe ? rxRatePinOut : 1'h1;
endmodule : mcp_front_model

// ### testbench/mcp_pin_monitor.sv
/* port assertions for the pin logic.
   assumes one clock domain; bound into the design top. */
`timescale 1ns/1ps
module mcp_pin_monitor (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrStb,
    input wire logic       regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic       txOffPin,
    input wire logic       irqReq,
    input wire logic       tx_off_pin,
    input wire logic       supplySenseEnable,
    input wire logic       irqPinOut,
    input wire logic       irqPinOe,
    input wire logic       auxOdPinOut,
    input wire logic       sigAbsentPinOut,
    input wire logic [2:0] resetPulseReq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // pin and register effects
    a_tx_off_pin: assert property (txOffPin |-> tx_off_pin)
        else $error("tx on with pin high");
    a_soft_off: assert property (regWrStb && regAddr == mcp_pkg::ADDR_SOFT_CTL
        && regWrData[0] |=> tx_off_pin) else $error("soft off ignored");
    a_irq_drive: assert property (irqPinOe |-> irqReq && !supplySenseEnable)
        else $error("pin14 pulled wrongly");
    a_pin14_sel: assert property (regWrStb && regAddr == mcp_pkg::ADDR_USER_CTL
        |=> supplySenseEnable != $past(regWrData[4])) else $error("pin14 select");
    a_od_low: assert property (!(irqPinOut || auxOdPinOut || sigAbsentPinOut))
        else $error("open drain driven high");
    a_rd_idle: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
        else $error("read data outside slot");
    a_rst_req: assert property (regWrStb && regAddr == mcp_pkg::ADDR_RESET_CTL
        |=> resetPulseReq == $past(regWrData[2:0])) else $error("reset request");
    a_rst_hold: assert property (!$past(regWrStb) |-> $stable(resetPulseReq))
        else $error("reset request moved");
    a_tx_status: assert property (regRdStb && regAddr == mcp_pkg::ADDR_STATUS
        && $past(txOffPin) |=> regRdData[0]) else $error("status bit");
    c_soft: cover property (regWrStb && regAddr == mcp_pkg::ADDR_SOFT_CTL);
    c_irq: cover property (irqPinOe);
    c_req: cover property (resetPulseReq != 3'h0);
endmodule : mcp_pin_monitor
bind mcp_module_control_pin_logic mcp_pin_monitor mon (.*);

// ### testbench/mcp_module_control_pin_logic_test.sv
/* bench for the pin logic: register tasks and pin scenarios.
   assumes the front-end model resolves the open-drain lines. */
`timescale 1ns/1ps
module mcp_module_control_pin_logic_test;
    logic       clock = '0, arst_n = '0, regWrStb = '0, regRdStb = '0, irqReq = '0;
    logic       txOffPin = '0, rxRateSelectPin = '0, txRateSelectPin = '0, extPull = '0;
    logic [3:0] regAddr = '0;
    logic [7:0] regWrData = '0, rxPowerInput = 8'h01, regRdData;
    logic [2:0] resetPulseReq;
    logic       tx_off_pin, supplySenseEnable, irqPinOut, irqPinOe, auxOdPinOut, auxOdPinOe;
    logic       sigAbsentPinIn, sigAbsentPinOut, sigAbsentPinOe, rxRatePinOut, rxRatePinOe, rxLvl;
    int         err_total = 0, total_checks = 0;
    always #5 clock = ~clock;
    mcp_module_control_pin_logic uut (.*);
    mcp_front_model frontEnd (.*);
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'h1;
        @(posedge clock);
        regWrStb <= 1'h0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        regAddr <= a;
        regRdStb <= 1'h1;
        @(posedge clock);
        regRdStb <= 1'h0;
        #1;
        chk("regRdData", e, regRdData);
    endtask : rd
    task automatic wt;
        repeat (3) @(posedge clock);
        #1;
    endtask : wt
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        err_total++;
        give_verdict;
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'h1;
        @(posedge clock) txOffPin <= 1'h1;
        wt;
        chk("tx_off_pin", 8'h01, {7'h0, tx_off_pin});
        rd(mcp_pkg::ADDR_STATUS, 8'h01);
        @(posedge clock) txOffPin <= 1'h0;
        wr(mcp_pkg::ADDR_SOFT_CTL, 8'h01);
        wt;
        chk("tx_off_pin", 8'h01, {7'h0, tx_off_pin});
        rd(mcp_pkg::ADDR_STATUS, 8'h00);
        wr(mcp_pkg::ADDR_SOFT_CTL, 8'h00);
        $display("test tx off done");
        @(posedge clock) irqReq <= 1'h1;
        wt;
        chk("pin14", 8'h02, {6'h0, supplySenseEnable, irqPinOe});
        wr(mcp_pkg::ADDR_USER_CTL, 8'h10);
        chk("pin14", 8'h01, {6'h0, supplySenseEnable, irqPinOe});
        $display("test pin14 done");
        chk("rxLvl", 8'h00, {7'h0, rxLvl});
        @(posedge clock) rxRateSelectPin <= 1'h1;
        wt;
        chk("rxPin", 8'h01, {6'h0, rxRatePinOe, rxLvl});
        rd(mcp_pkg::ADDR_STATUS, 8'h02);
        @(posedge clock) rxRateSelectPin <= 1'h0;
        wr(mcp_pkg::ADDR_SOFT_CTL, 8'h02);
        chk("rxLvl", 8'h01, {7'h0, rxLvl});
        wr(mcp_pkg::ADDR_OEM_CFG3, 8'h13);
        chk("rxPin", 8'h03, {6'h0, rxRatePinOe, rxRatePinOut});
        wr(mcp_pkg::ADDR_OEM_CFG3, 8'h10);
        chk("rxLvl", 8'h00, {7'h0, rxLvl});
        $display("test pin20 done");
        wr(mcp_pkg::ADDR_THRESH, 8'h40);
        @(posedge clock) rxPowerInput <= 8'h40;
        wt;
        rd(mcp_pkg::ADDR_STATUS, 8'h08);
        @(posedge clock) rxPowerInput <= 8'h41;
        wt;
        chk("lossLvl", 8'h00, {7'h0, sigAbsentPinIn});
        wr(mcp_pkg::ADDR_OEM_CFG6, 8'h08);
        chk("lossLvl", 8'h01, {7'h0, sigAbsentPinIn});
        @(posedge clock) extPull <= 1'h1;
        wt;
        rd(mcp_pkg::ADDR_STATUS, 8'h08);
        @(posedge clock) extPull <= 1'h0;
        wr(mcp_pkg::ADDR_OEM_CFG6, 8'h04);
        @(posedge clock) txRateSelectPin <= 1'h1;
        wt;
        rd(mcp_pkg::ADDR_STATUS, 8'h0c);
        @(posedge clock) txRateSelectPin <= 1'h0;
        wt;
        chk("rateLvl", 8'h00, {7'h0, sigAbsentPinIn});
        wr(mcp_pkg::ADDR_SOFT_CTL, 8'h04);
        chk("rateLvl", 8'h01, {7'h0, sigAbsentPinIn});
        $display("test pin19 done");
        wr(mcp_pkg::ADDR_OEM_CFG3, 8'h08);
        chk("auxOe", 8'h00, {7'h0, auxOdPinOe});
        wr(mcp_pkg::ADDR_OEM_CFG3, 8'h80);
        wr(mcp_pkg::ADDR_RESET_CTL, 8'h05);
        chk("aux", 8'h0d, {4'h0, auxOdPinOe, resetPulseReq});
        wr(mcp_pkg::ADDR_RESET_CTL, 8'h00);
        chk("auxOe", 8'h00, {7'h0, auxOdPinOe});
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        $display("test aux done");
        give_verdict;
    end
endmodule : mcp_module_control_pin_logic_test
